// file: hw/oscctl_top.sv
// Oscillator control register with AXI4-Lite slave access.
// Assumes config straps are stable levels from outside this clock domain.
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module oscctl_top
    import oscctl_pkg::*;
(
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [3:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [3:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic pll_force_config, // Config PLL force strap
    output logic pll_enable, // 4x PLL on
    output oscctl_sys_type sysclk_select, // System clock source
    output logic [31:0] freq_hz, // Internal oscillator rate
    output oscctl_osc_type freq_source // Oscillator behind the rate
);
    // Register contents and handshake state
    logic [7:0] osc_control;
    logic [7:0] next_osc_control;
    logic aw_held, w_held, next_aw_held, next_w_held;
    logic [3:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic [1:0] next_bresp, next_rresp;
    logic next_bvalid, next_rvalid;
    logic [31:0] next_rdata;
    logic force_meta, force_sync;
    logic next_pll_enable;
    oscctl_sys_type next_sysclk_select;
    logic do_write, do_read;

    wire logic soft_pll_enable = osc_control[OSCCTL_PLL_BIT];
    wire logic [3:0] internal_freq_select = osc_control[OSCCTL_FREQ_LSB +: 4];
    wire logic [1:0] sysclk_source_select = osc_control[OSCCTL_SRC_LSB +: 2];

    // Address and data are taken in either order; each held until used
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_read = s_axi_arvalid && s_axi_arready;

    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        do_write = next_aw_held && next_w_held && !s_axi_bvalid;
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
        end
    end

    // Register update; bit 2 never stores so it always reads zero
    always_comb
    begin
        next_osc_control = osc_control;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        if (do_write)
        begin
            next_bvalid = 1'b1;
            if (next_aw_addr[3:2] == OSCCTL_OSC_CONTROL_ADDR[3:2])
            begin
                next_bresp = OSCCTL_AXI_OKAY;
                if (next_w_strb[0])
                    next_osc_control = next_w_data[7:0]
                                       & OSCCTL_WRITE_MASK;
            end
            else
                next_bresp = OSCCTL_AXI_SLVERR;
        end
    end

    // Read path; unmapped addresses answer SLVERR with zero data
    always_comb
    begin
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (do_read)
        begin
            next_rvalid = 1'b1;
            if (s_axi_araddr[3:2] == OSCCTL_OSC_CONTROL_ADDR[3:2])
            begin
                next_rdata = {24'h000000, osc_control};
                next_rresp = OSCCTL_AXI_OKAY;
            end
            else
            begin
                next_rdata = 32'h00000000;
                next_rresp = OSCCTL_AXI_SLVERR;
            end
        end
    end

    // PLL and source selection from fields and the synced strap
    always_comb
    begin
        next_pll_enable = force_sync ? 1'b1 : soft_pll_enable;
        if (sysclk_source_select[1])
            next_sysclk_select = OSCCTL_SYS_INTERNAL;
        else if (sysclk_source_select[0])
            next_sysclk_select = OSCCTL_SYS_TIMER1;
        else
            next_sysclk_select = OSCCTL_SYS_CONFIG;
    end

    // All state registers; every reset gives the same field values
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            osc_control <= OSCCTL_RESET_VALUE;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= OSCCTL_AXI_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= OSCCTL_AXI_OKAY;
            force_meta <= 1'b0;
            force_sync <= 1'b0;
            pll_enable <= 1'b0;
            sysclk_select <= OSCCTL_SYS_CONFIG;
        end
        else
        begin
            osc_control <= next_osc_control;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            force_meta <= pll_force_config; // Strap from outside domain
            force_sync <= force_meta;
            pll_enable <= next_pll_enable;
            sysclk_select <= next_sysclk_select;
        end
    end

    // Rate decoder; PLL state feeds the 8/32 MHz choice
    oscctl_decode u_decode (
        .aclk(aclk),
        .aresetn(aresetn),
        .internal_freq_select(internal_freq_select),
        .pll_active(pll_enable),
        .freq_hz(freq_hz),
        .freq_source(freq_source)
    );

    // Forced PLL is on one cycle after the synced strap is high
    pll_forced_a: assert property (@(posedge aclk) disable iff (!aresetn)
        force_sync |=> pll_enable)
        else $error("PLL not on while forced");
    pll_soft_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !force_sync |=> pll_enable == $past(soft_pll_enable))
        else $error("PLL does not follow soft enable");
    freq_top_a: assert property (@(posedge aclk) disable iff (!aresetn)
        internal_freq_select == OSCCTL_F16M |=> freq_hz == 32'd16000000)
        else $error("Code 1111 not 16 MHz");
    freq_pll_a: assert property (@(posedge aclk) disable iff (!aresetn)
        internal_freq_select == OSCCTL_F8M && pll_enable
        |=> freq_hz == 32'd32000000)
        else $error("Code 1110 with PLL not 32 MHz");
    freq_dup_a: assert property (@(posedge aclk) disable iff (!aresetn)
        internal_freq_select == OSCCTL_F125K_HF
        |=> freq_hz == 32'd125000 && freq_source == OSCCTL_OSC_HF)
        else $error("Code 1000 not fast 125 kHz");
    reset_code_a: assert property (@(posedge aclk)
        !aresetn |=> internal_freq_select == OSCCTL_F500K_MF)
        else $error("Reset did not load 0111");
    freq_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        internal_freq_select == OSCCTL_F31K_MF
        |=> freq_hz == 32'd31250 && freq_source == OSCCTL_OSC_MF)
        else $error("Code 0011 not medium 31.25 kHz");
    src_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sysclk_source_select[1] |=> sysclk_select == OSCCTL_SYS_INTERNAL)
        else $error("Source 1x not internal");
    bit_two_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_rdata[2])
        else $error("Bit 2 read as one");
    freq_fast31_a: assert property (@(posedge aclk) disable iff (!aresetn)
        internal_freq_select == OSCCTL_F31K_HF
        |=> freq_hz == 32'd31250 && freq_source == OSCCTL_OSC_HF)
        else $error("Code 0100 not fast 31.25 kHz");
endmodule // oscctl_top

// file: hw/oscctl_pkg.sv
// Package for the oscillator control register block.
// Assumes a single 100 MHz clock and an AXI4-Lite register bus.
package oscctl_pkg;
    // Register map, byte address of the only register
    localparam logic [3:0] OSCCTL_OSC_CONTROL_ADDR = 4'h0;
    localparam int OSCCTL_ADDR_WIDTH = 4;
    // Field positions
    localparam int OSCCTL_PLL_BIT = 7;
    localparam int OSCCTL_FREQ_LSB = 3;
    localparam int OSCCTL_SRC_LSB = 0;
    // Value after any reset
    localparam logic [7:0] OSCCTL_RESET_VALUE = 8'h38;
    // Rate shown after reset, 500 kHz for the reset code 0111
    localparam logic [31:0] OSCCTL_RESET_FREQ_HZ = 32'h0007a120;
    localparam logic [7:0] OSCCTL_WRITE_MASK = 8'hfb;
    // Frequency select codes
    localparam logic [3:0] OSCCTL_F16M = 4'hf;
    localparam logic [3:0] OSCCTL_F8M = 4'he;
    localparam logic [3:0] OSCCTL_F4M = 4'hd;
    localparam logic [3:0] OSCCTL_F2M = 4'hc;
    localparam logic [3:0] OSCCTL_F1M = 4'hb;
    localparam logic [3:0] OSCCTL_F500K_HF = 4'ha;
    localparam logic [3:0] OSCCTL_F250K_HF = 4'h9;
    localparam logic [3:0] OSCCTL_F125K_HF = 4'h8;
    localparam logic [3:0] OSCCTL_F500K_MF = 4'h7;
    localparam logic [3:0] OSCCTL_F250K_MF = 4'h6;
    localparam logic [3:0] OSCCTL_F125K_MF = 4'h5;
    localparam logic [3:0] OSCCTL_F31K_HF = 4'h4;
    localparam logic [3:0] OSCCTL_F31K_MF = 4'h3;
    // Oscillator source ids
    typedef enum logic [1:0] {
        OSCCTL_OSC_NONE = 2'h0,
        OSCCTL_OSC_HF = 2'h1,
        OSCCTL_OSC_MF = 2'h2
    } oscctl_osc_type;
    // System clock source ids
    typedef enum logic [1:0] {
        OSCCTL_SYS_CONFIG = 2'h0,
        OSCCTL_SYS_TIMER1 = 2'h1,
        OSCCTL_SYS_INTERNAL = 2'h2
    } oscctl_sys_type;
    localparam logic [1:0] OSCCTL_AXI_OKAY = 2'h0;
    localparam logic [1:0] OSCCTL_AXI_SLVERR = 2'h2;
endpackage

// file: hw/oscctl_decode.sv
// Frequency decoder for the internal oscillator select field.
// Assumes a registered field on the same clock; output is registered.
`timescale 1ns/1ps
module oscctl_decode
    import oscctl_pkg::*;
(
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [3:0] internal_freq_select, // Frequency code
    input wire logic pll_active, // PLL in effect
    output logic [31:0] freq_hz, // Decoded rate in Hz
    output oscctl_osc_type freq_source // Oscillator used
);
    logic [31:0] next_freq_hz;
    oscctl_osc_type next_freq_source;

    // Decode the code to a rate and the oscillator that yields it
    always_comb
    begin
        next_freq_source = OSCCTL_OSC_HF;
        unique case (internal_freq_select)
            OSCCTL_F16M: next_freq_hz = 32'd16000000;
            OSCCTL_F8M: next_freq_hz = pll_active ? 32'd32000000
                                                  : 32'd8000000;
            OSCCTL_F4M: next_freq_hz = 32'd4000000;
            OSCCTL_F2M: next_freq_hz = 32'd2000000;
            OSCCTL_F1M: next_freq_hz = 32'd1000000;
            OSCCTL_F500K_HF: next_freq_hz = 32'd500000;
            OSCCTL_F250K_HF: next_freq_hz = 32'd250000;
            OSCCTL_F125K_HF: next_freq_hz = 32'd125000;
            OSCCTL_F31K_HF: next_freq_hz = 32'd31250;
            OSCCTL_F500K_MF:
            begin
                next_freq_hz = 32'd500000;
                next_freq_source = OSCCTL_OSC_MF;
            end
            OSCCTL_F250K_MF:
            begin
                next_freq_hz = 32'd250000;
                next_freq_source = OSCCTL_OSC_MF;
            end
            OSCCTL_F125K_MF:
            begin
                next_freq_hz = 32'd125000;
                next_freq_source = OSCCTL_OSC_MF;
            end
            default:
            begin
                // Codes 0000 to 0011 all mean mid-frequency 31.25 kHz
                next_freq_hz = 32'd31250;
                next_freq_source = OSCCTL_OSC_MF;
            end
        endcase
    end

    // Register the decode so the outputs come from flip-flops
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            freq_hz <= OSCCTL_RESET_FREQ_HZ;
            freq_source <= OSCCTL_OSC_MF;
        end
        else
        begin
            freq_hz <= next_freq_hz;
            freq_source <= next_freq_source;
        end
    end
endmodule // oscctl_decode

// file: verification/oscctl_top_test.sv
// Self-checking bench for the oscillator control register block.
// Assumes the AXI4-Lite slave of oscctl_top and a 100 MHz clock.
`timescale 1ns/1ps
module oscctl_top_test
    import oscctl_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, pll_force_config;
    logic pll_enable;
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr, code;
    logic [31:0] s_axi_wdata, s_axi_rdata, freq_hz;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    oscctl_sys_type sysclk_select;
    oscctl_osc_type freq_source;
    int failures = 0;
    int n_compared = 0;

    oscctl_top dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pll_force_config(pll_force_config),
        .pll_enable(pll_enable), .sysclk_select(sysclk_select),
        .freq_hz(freq_hz), .freq_source(freq_source)
    );

    // 100 MHz clock
    always #5 aclk = ~aclk;

    // Compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Write; each valid is dropped on its own handshake edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] st, input logic [1:0] er);
    begin
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // No local limit: only the watchdog may end a hung wait
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        check({30'h0, s_axi_bresp}, {30'h0, er});
    end
    endtask

    // Read; rready stays high until the answer is sampled
    task automatic rd(input logic [3:0] a, input logic [31:0] d,
        input logic [1:0] er);
    begin
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, d);
        check({30'h0, s_axi_rresp}, {30'h0, er});
    end
    endtask

    // Expected rate for a select code; 8 MHz becomes 32 MHz with PLL
    function automatic logic [31:0] exp_hz(input logic [3:0] c,
        input logic p);
        case (c)
            4'hf: exp_hz = 32'hf42400;
            4'he: exp_hz = p ? 32'h1e84800 : 32'h7a1200;
            4'hd: exp_hz = 32'h3d0900;
            4'hc: exp_hz = 32'h1e8480;
            4'hb: exp_hz = 32'hf4240;
            4'ha, 4'h7: exp_hz = 32'h7a120;
            4'h9, 4'h6: exp_hz = 32'h3d090;
            4'h8, 4'h5: exp_hz = 32'h1e848;
            default: exp_hz = 32'h7a12;
        endcase
    endfunction

    task automatic conclude();
    begin
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask

    // Watchdog, well beyond the few hundred cycles the tests take
    initial
    begin
        #200000;
        failures++;
        conclude();
    end

    // Main sequence
    initial
    begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, pll_force_config} = '0;
        {s_axi_awaddr, s_axi_wstrb, s_axi_araddr, code} = '0;
        s_axi_wdata = '0;
        tick(20);
        aresetn <= 1'b1;
        tick(1);
        rd(4'h0, 32'h38, OSCCTL_AXI_OKAY);
        check({31'h0, pll_enable}, 32'h0);
        check(freq_hz, exp_hz(4'h7, 1'b0));
        check({30'h0, freq_source}, {30'h0, OSCCTL_OSC_MF});
        check({30'h0, sysclk_select}, {30'h0, OSCCTL_SYS_CONFIG});
        // Every select code, bit 2 written high, source 1x
        for (int i = 0; i < 16; i++)
        begin
            code = i[3:0];
            wr(4'h0, {24'h0, 1'b0, code, 2'h3, i[0]}, 4'hf,
                OSCCTL_AXI_OKAY);
            rd(4'h0, {24'h0, 1'b0, code, 2'h1, i[0]}, OSCCTL_AXI_OKAY);
            tick(3);
            check(freq_hz, exp_hz(code, 1'b0));
            check({30'h0, freq_source},
                (code[3] || code == 4'h4) ? 32'h1 : 32'h2);
            check({30'h0, sysclk_select}, 32'h2);
        end
        // Software PLL enable with config source, then Timer1
        wr(4'h0, 32'hf0, 4'hf, OSCCTL_AXI_OKAY);
        tick(3);
        check({31'h0, pll_enable}, 32'h1);
        check(freq_hz, exp_hz(4'he, 1'b1));
        check({30'h0, sysclk_select}, 32'h0);
        wr(4'h0, 32'h71, 4'hf, OSCCTL_AXI_OKAY);
        tick(3);
        check({31'h0, pll_enable}, 32'h0);
        check(freq_hz, exp_hz(4'he, 1'b0));
        check({30'h0, sysclk_select}, 32'h1);
        // Config force overrides a cleared enable bit
        pll_force_config <= 1'b1;
        tick(6);
        check({31'h0, pll_enable}, 32'h1);
        check(freq_hz, exp_hz(4'he, 1'b1));
        pll_force_config <= 1'b0;
        tick(6);
        check({31'h0, pll_enable}, 32'h0);
        // Unmapped address and empty strobe leave the register alone
        wr(4'h4, 32'hff, 4'hf, OSCCTL_AXI_SLVERR);
        rd(4'h4, 32'h0, OSCCTL_AXI_SLVERR);
        wr(4'h0, 32'hff, 4'h0, OSCCTL_AXI_OKAY);
        rd(4'h0, 32'h71, OSCCTL_AXI_OKAY);
        // Reset in mid-run reloads the defaults
        aresetn <= 1'b0;
        tick(2);
        aresetn <= 1'b1;
        tick(1);
        rd(4'h0, 32'h38, OSCCTL_AXI_OKAY);
        tick(2);
        check(freq_hz, exp_hz(4'h7, 1'b0));
        conclude();
    end
endmodule // oscctl_top_test
